// ===== core/snfe_pkg.sv
`default_nettype none
package snfe_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int unsigned MAIN_BYTES = 2048;
  localparam int unsigned SPARE_BYTES = 128;
  localparam logic [11:0] PAGE_BYTES = 12'(MAIN_BYTES + SPARE_BYTES);
  localparam int unsigned BLOCKS = 512;
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam logic [15:0] ROW_MASK = 16'(BLOCKS * PAGES_PER_BLOCK - 1);

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_FEAT_RD = 8'h0F;
  localparam logic [7:0] OP_FEAT_WR = 8'h1F;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
  localparam logic [7:0] OP_DEV_RESET = 8'hFF;
  localparam logic [7:0] OP_RD_X1 = 8'h03;
  localparam logic [7:0] OP_RD_X2 = 8'h3B;
  localparam logic [7:0] OP_RD_X4 = 8'h6B;
  localparam logic [7:0] OP_LD_X1 = 8'h02;
  localparam logic [7:0] OP_LD_X4 = 8'h32;

  // ----------------------------------------------------------------
  // feature register kept in the front end, plus link and buffer constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'hB0;
  localparam int unsigned QUAD_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LANES_OFF = 4'hF;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_WIDTH = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LW_X1, LW_X2, LW_X4} snfe_lw_t;
  typedef enum logic [2:0] {K_BAD, K_NONE, K_ROW, K_FRD, K_FWR, K_RD, K_LD} snfe_kind_t;
  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_DUMMY, S_DIN, S_DOUT, S_DONE} snfe_st_t;

  typedef struct packed {
    snfe_kind_t kind;
    logic [1:0] nbytes;
    snfe_lw_t lw;
    logic quad;
  } snfe_info_t;

endpackage : snfe_pkg
`default_nettype wire

// ===== core/snfe_fifo_if.sv
`default_nettype none
interface snfe_fifo_if;
  logic in_valid;
  logic in_ready;
  logic [7:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;

  modport fifo (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );
  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface : snfe_fifo_if
`default_nettype wire

// ===== core/snfe_buf.sv
`default_nettype none
module snfe_buf (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // both sides of the buffer
  snfe_fifo_if.fifo f
);

  typedef struct packed {
    logic [snfe_pkg::BUF_DEPTH-1:0][snfe_pkg::BUF_WIDTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } snfe_buf_st_t;

  snfe_buf_st_t s_q;
  snfe_buf_st_t s_d;
  logic push;
  logic pull;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign f.in_ready = (s_q.cnt != 2'(snfe_pkg::BUF_DEPTH));
  assign f.out_valid = (s_q.cnt != 2'h0);
  assign f.out_data = s_q.mem[s_q.rp];
  assign push = f.in_valid & f.in_ready;
  assign pull = f.out_valid & f.out_ready;

  // pointer and count update; push and pull may share a cycle
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = f.in_data;
      s_d.wp = ~s_q.wp;
    end
    if (pull) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + 2'(push) - 2'(pull);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : snfe_buf
`default_nettype wire

// ===== core/snfe_front.sv
// How it works
// - single lane: input bits on lane zero, taken on each rising link clock edge
// - single lane: output bit on lane one, updated after each falling edge
// - clock idle level at select edges may be low (mode 0) or high (mode 3)
// - dual instructions move data two bits per edge on lanes zero and one
// - quad instructions move data four bits per edge on lanes zero to three
// - quad instructions are ignored unless the quad lane enable bit is set
// - select high floats every lane; select low accepts instructions
// - deselect never aborts an internal operation already handed to the core
// - after reset, a high to low select transition is needed before any instruction
// - lane zero is input for commands and address, output when returning data at dual or quad width
// - column address spans 2176 bytes, 2048 main plus 128 spare
// - row address selects one of 512 x 64 = 32768 pages
// - pause pin low with clock low freezes the link and floats outputs, while the quad lane enable bit is clear
// - feature read and write carry a one-byte register address
`default_nettype none
module snfe_front (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_n,
  // decoded instruction towards the core
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_row,
  output logic [11:0] cmd_col,
  // program data towards the core
  output logic prog_valid,
  output logic [7:0] prog_data,
  // feature register access
  output logic feat_wr_valid,
  output logic [7:0] feat_addr,
  output logic [7:0] feat_wr_data,
  input wire logic [7:0] feat_rd_data,
  output logic quad_lane_enable,
  // read data from the core
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_p;
    logic ck_s1;
    logic ck_s2;
    logic ck_p;
    logic [3:0] ln_s1;
    logic [3:0] ln_s2;
    snfe_pkg::snfe_st_t st;
    snfe_pkg::snfe_lw_t lw;
    logic [7:0] op;
    logic [7:0] sh;
    logic [3:0] bits;
    logic [1:0] nbyte;
    logic [15:0] addr;
    logic [7:0] out_sh;
    logic [3:0] drv;
    logic [3:0] oe_n;
    logic paused;
    logic [7:0] cfg;
    logic cmd_v;
    logic [7:0] cmd_code;
    logic [15:0] row;
    logic [11:0] col;
    logic prog_v;
    logic [7:0] prog_d;
    logic fw_v;
    logic [7:0] fa;
    logic [7:0] fd;
  } snfe_front_st_t;

  snfe_front_st_t s_q;
  snfe_front_st_t s_d;
  logic pop;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic snfe_pkg::snfe_info_t decode(input logic [7:0] op);
    snfe_pkg::snfe_info_t i;
    i = '{kind: snfe_pkg::K_BAD, nbytes: 2'h0, lw: snfe_pkg::LW_X1, quad: 1'b0};
    unique case (op)
      snfe_pkg::OP_FEAT_RD: i = '{snfe_pkg::K_FRD, 2'h1, snfe_pkg::LW_X1, 1'b0};
      snfe_pkg::OP_FEAT_WR: i = '{snfe_pkg::K_FWR, 2'h1, snfe_pkg::LW_X1, 1'b0};
      snfe_pkg::OP_PAGE_READ,
      snfe_pkg::OP_PROG_EXEC,
      snfe_pkg::OP_BLK_ERASE: i = '{snfe_pkg::K_ROW, 2'h3, snfe_pkg::LW_X1, 1'b0};
      snfe_pkg::OP_DEV_RESET: i = '{snfe_pkg::K_NONE, 2'h0, snfe_pkg::LW_X1, 1'b0};
      snfe_pkg::OP_RD_X1: i = '{snfe_pkg::K_RD, 2'h2, snfe_pkg::LW_X1, 1'b0};
      snfe_pkg::OP_RD_X2: i = '{snfe_pkg::K_RD, 2'h2, snfe_pkg::LW_X2, 1'b0};
      snfe_pkg::OP_RD_X4: i = '{snfe_pkg::K_RD, 2'h2, snfe_pkg::LW_X4, 1'b1};
      snfe_pkg::OP_LD_X1: i = '{snfe_pkg::K_LD, 2'h2, snfe_pkg::LW_X1, 1'b0};
      snfe_pkg::OP_LD_X4: i = '{snfe_pkg::K_LD, 2'h2, snfe_pkg::LW_X4, 1'b1};
      default: i = '{snfe_pkg::K_BAD, 2'h0, snfe_pkg::LW_X1, 1'b0};
    endcase
    return i;
  endfunction

  // bits moved per link clock edge for a lane width
  function automatic logic [3:0] lane_step(input snfe_pkg::snfe_lw_t lw);
    unique case (lw)
      snfe_pkg::LW_X1: return 4'h1;
      snfe_pkg::LW_X2: return 4'h2;
      snfe_pkg::LW_X4: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction

  // column advance wraps at the end of the spare area
  function automatic logic [11:0] next_col(input logic [11:0] c);
    return (c == snfe_pkg::PAGE_BYTES - 12'h001) ? 12'h000 : c + 12'h001;
  endfunction

  // ----------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------
  snfe_fifo_if fif ();

  assign fif.in_valid = rd_valid;
  assign fif.in_data = rd_data;
  assign fif.out_ready = pop;
  assign rd_ready = fif.in_ready;

  // two entries let the core refill while a byte is still shifting out
  snfe_buf u_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .f(fif.fifo)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic cs_fall;
    logic [3:0] step;
    logic [3:0] bits_nxt;
    logic done;
    logic [7:0] byte_in;
    logic [7:0] cur;
    logic [7:0] fresh;
    logic [11:0] raw_col;
    snfe_pkg::snfe_info_t info;
    snfe_pkg::snfe_info_t cur_info;
    s_d = s_q;
    pop = 1'b0;
    s_d.cmd_v = 1'b0;
    s_d.prog_v = 1'b0;
    s_d.fw_v = 1'b0;
    // pin synchronisers; only the second stage and its delayed copy are looked at
    s_d.cs_s1 = cs_n;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.cs_p = s_q.cs_s2;
    s_d.ck_s1 = sclk;
    s_d.ck_s2 = s_q.ck_s1;
    s_d.ck_p = s_q.ck_s2;
    s_d.ln_s1 = lane_in;
    s_d.ln_s2 = s_q.ln_s1;
    // edges are found on the sampled clock, so either idle level works
    rise = s_q.ck_s2 & ~s_q.ck_p;
    fall = ~s_q.ck_s2 & s_q.ck_p;
    cs_fall = ~s_q.cs_s2 & s_q.cs_p;
    step = lane_step(s_q.lw);
    bits_nxt = s_q.bits + step;
    done = (bits_nxt == snfe_pkg::BYTE_BITS);
    unique case (s_q.lw)
      snfe_pkg::LW_X2: byte_in = {s_q.sh[5:0], s_q.ln_s2[1:0]};
      snfe_pkg::LW_X4: byte_in = {s_q.sh[3:0], s_q.ln_s2[3:0]};
      default: byte_in = {s_q.sh[6:0], s_q.ln_s2[0]};
    endcase
    info = decode(byte_in);
    cur_info = decode(s_q.op);
    raw_col = {s_q.addr[3:0], byte_in};
    fresh = snfe_pkg::FILL_BYTE;
    cur = s_q.out_sh;
    if (s_q.cs_s2) begin
      // deselected: float, drop any partial instruction
      s_d.oe_n = snfe_pkg::LANES_OFF;
      s_d.paused = 1'b0;
      s_d.bits = 4'h0;
      s_d.st = snfe_pkg::S_IDLE;
    end else if (s_q.st == snfe_pkg::S_IDLE) begin
      // a low select seen without a preceding high never starts a frame
      if (cs_fall) begin
        s_d.st = snfe_pkg::S_OPC;
        s_d.lw = snfe_pkg::LW_X1;
        s_d.bits = 4'h0;
      end
    end else begin
      // the pause pin changes state only while the clock is low
      if (!s_q.cfg[snfe_pkg::QUAD_BIT] && !s_q.ck_s2) begin
        s_d.paused = ~s_q.ln_s2[3];
      end
      if (s_q.paused) begin
        s_d.oe_n = snfe_pkg::LANES_OFF;
      end else begin
        unique case (s_q.st)
          snfe_pkg::S_OPC: begin
            if (rise) begin
              s_d.sh = byte_in;
              s_d.bits = bits_nxt;
              if (done) begin
                s_d.op = byte_in;
                s_d.bits = 4'h0;
                s_d.nbyte = 2'h0;
                if (info.kind == snfe_pkg::K_BAD) begin
                  s_d.st = snfe_pkg::S_DONE;
                end else if (info.quad && !s_q.cfg[snfe_pkg::QUAD_BIT]) begin
                  s_d.st = snfe_pkg::S_DONE;
                end else if (info.kind == snfe_pkg::K_NONE) begin
                  s_d.cmd_v = 1'b1;
                  s_d.cmd_code = byte_in;
                  s_d.st = snfe_pkg::S_DONE;
                end else begin
                  s_d.st = snfe_pkg::S_ADDR;
                end
              end
            end
          end
          snfe_pkg::S_ADDR: begin
            if (rise) begin
              s_d.sh = byte_in;
              s_d.bits = bits_nxt;
              if (done) begin
                s_d.bits = 4'h0;
                s_d.addr = {s_q.addr[7:0], byte_in};
                s_d.nbyte = s_q.nbyte + 2'h1;
                if (s_q.nbyte + 2'h1 == cur_info.nbytes) begin
                  s_d.cmd_code = s_q.op;
                  unique case (cur_info.kind)
                    snfe_pkg::K_ROW: begin
                      // handed over whole; a later deselect does not cancel it
                      s_d.row = {s_q.addr[7:0], byte_in} & snfe_pkg::ROW_MASK;
                      s_d.cmd_v = 1'b1;
                      s_d.st = snfe_pkg::S_DONE;
                    end
                    snfe_pkg::K_FRD: begin
                      s_d.fa = byte_in;
                      s_d.st = snfe_pkg::S_DOUT;
                    end
                    snfe_pkg::K_FWR: begin
                      s_d.fa = byte_in;
                      s_d.st = snfe_pkg::S_DIN;
                    end
                    snfe_pkg::K_RD: begin
                      s_d.col = (raw_col < snfe_pkg::PAGE_BYTES) ? raw_col : 12'h000;
                      s_d.cmd_v = 1'b1;
                      s_d.st = snfe_pkg::S_DUMMY;
                    end
                    default: begin
                      s_d.col = (raw_col < snfe_pkg::PAGE_BYTES) ? raw_col : 12'h000;
                      s_d.cmd_v = 1'b1;
                      s_d.lw = cur_info.lw;
                      s_d.st = snfe_pkg::S_DIN;
                    end
                  endcase
                end
              end
            end
          end
          snfe_pkg::S_DUMMY: begin
            // one dummy byte gives the core time to fill the buffer
            if (rise) begin
              s_d.bits = bits_nxt;
              if (done) begin
                s_d.bits = 4'h0;
                s_d.lw = cur_info.lw;
                s_d.st = snfe_pkg::S_DOUT;
              end
            end
          end
          snfe_pkg::S_DIN: begin
            if (rise) begin
              s_d.sh = byte_in;
              s_d.bits = bits_nxt;
              if (done) begin
                s_d.bits = 4'h0;
                if (cur_info.kind == snfe_pkg::K_FWR) begin
                  s_d.fw_v = 1'b1;
                  s_d.fd = byte_in;
                  if (s_q.fa == snfe_pkg::CFG_ADDR) begin
                    s_d.cfg = byte_in;
                  end
                  s_d.st = snfe_pkg::S_DONE;
                end else begin
                  s_d.prog_v = 1'b1;
                  s_d.prog_d = byte_in;
                  s_d.col = next_col(s_q.col);
                end
              end
            end
          end
          snfe_pkg::S_DOUT: begin
            // output moves only after a falling edge, stable for the next rise
            if (fall) begin
              if (cur_info.kind == snfe_pkg::K_FRD) begin
                fresh = (s_q.fa == snfe_pkg::CFG_ADDR) ? s_q.cfg : feat_rd_data;
              end else if (fif.out_valid) begin
                fresh = fif.out_data;
              end
              if (s_q.bits == 4'h0) begin
                cur = fresh;
                if (cur_info.kind == snfe_pkg::K_RD) begin
                  pop = fif.out_valid;
                  s_d.col = next_col(s_q.col);
                end
              end
              unique case (s_q.lw)
                snfe_pkg::LW_X2: begin
                  s_d.drv = {2'b00, cur[7:6]};
                  s_d.oe_n = 4'b1100;
                end
                snfe_pkg::LW_X4: begin
                  s_d.drv = cur[7:4];
                  s_d.oe_n = 4'b0000;
                end
                default: begin
                  s_d.drv = {2'b00, cur[7], 1'b0};
                  s_d.oe_n = 4'b1101;
                end
              endcase
              s_d.out_sh = cur << step;
              s_d.bits = done ? 4'h0 : bits_nxt;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.oe_n <= snfe_pkg::LANES_OFF;
      s_q.cfg <= snfe_pkg::CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lane_out = s_q.drv;
  assign lane_oe_n = s_q.oe_n;
  assign cmd_valid = s_q.cmd_v;
  assign cmd_code = s_q.cmd_code;
  assign cmd_row = s_q.row;
  assign cmd_col = s_q.col;
  assign prog_valid = s_q.prog_v;
  assign prog_data = s_q.prog_d;
  assign feat_wr_valid = s_q.fw_v;
  assign feat_addr = s_q.fa;
  assign feat_wr_data = s_q.fd;
  assign quad_lane_enable = s_q.cfg[snfe_pkg::QUAD_BIT];

endmodule : snfe_front
`default_nettype wire

// ===== test/snfe_front_asserts.sv
`default_nettype none
module snfe_front_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link side
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_n,
  input wire logic quad_lane_enable,
  // core side
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_row,
  input wire logic [11:0] cmd_col,
  input wire logic prog_valid,
  input wire logic feat_wr_valid,
  input wire logic [7:0] feat_addr,
  input wire logic [7:0] feat_wr_data,
  input wire logic rd_valid,
  input wire logic rd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----
  // helper state
  // ----
  logic seen_hi_q;
  logic quad_want_q;
  // select seen high since reset; quad bit carried by the last feature write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_hi_q <= 1'b0;
      quad_want_q <= 1'b0;
    end else begin
      seen_hi_q <= seen_hi_q | cs_n;
      if (feat_wr_valid) quad_want_q <= feat_wr_data[snfe_pkg::QUAD_BIT];
    end
  end
  sequence pulse_s;
    cmd_valid || prog_valid || feat_wr_valid;
  endsequence
  // two pushes while no frame is open, so nothing can drain in between
  sequence quiet_fill_s;
    cs_n [*4] ##1 (cs_n && rd_valid && rd_ready) [*2];
  endsequence
  // ----
  // assertions
  // ----
  float_idle_a: assert property (cs_n [*6] |-> lane_oe_n == snfe_pkg::LANES_OFF)
    else $error("lanes driven while deselected");
  // frame start and end excluded: the enables may move there on select alone
  fall_edge_out_a: assert property (!cs_n && !$past(cs_n, 5) && $changed({lane_out, lane_oe_n})
    |-> !$past(sclk, 2)) else $error("output moved outside a falling link edge");
  select_first_a: assert property (pulse_s |-> seen_hi_q)
    else $error("instruction taken before a select edge");
  pulse_in_frame_a: assert property (pulse_s |-> !$past(cs_n, 4))
    else $error("pulse without a selected frame");
  cmd_gap_a: assert property (cmd_valid |=> !cmd_valid [*8])
    else $error("instructions decoded too close together");
  prog_gap_a: assert property (prog_valid |=> !prog_valid [*3])
    else $error("program bytes faster than the lanes allow");
  row_range_a: assert property (cmd_valid |-> (cmd_row & ~snfe_pkg::ROW_MASK) == 16'h0000)
    else $error("row beyond the array");
  col_range_a: assert property (cmd_col < snfe_pkg::PAGE_BYTES)
    else $error("column beyond the page");
  quad_write_a: assert property (feat_wr_valid && feat_addr == snfe_pkg::CFG_ADDR
    |=> quad_lane_enable == quad_want_q) else $error("quad enable not taken from write");
  quad_lanes_a: assert property (!lane_oe_n[2] || !lane_oe_n[3] |-> quad_lane_enable)
    else $error("upper lanes driven with quad disabled");
  buf_full_a: assert property (quiet_fill_s |=> !rd_ready)
    else $error("buffer accepts a third byte");
endmodule // snfe_front_asserts

bind snfe_front snfe_front_asserts u_snfe_front_asserts (.core_clk, .arst_n, .sclk, .cs_n,
  .lane_out, .lane_oe_n, .quad_lane_enable, .cmd_valid, .cmd_row, .cmd_col, .prog_valid,
  .feat_wr_valid, .feat_addr, .feat_wr_data, .rd_valid, .rd_ready);
`default_nettype wire

// ===== test/snfe_host_model.sv
`default_nettype none
module snfe_host_model (
  // bench clock
  input wire logic core_clk,
  // pins towards the device
  output logic sclk,
  output logic cs_n,
  output logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mode3 = 1'b0;
  logic flt = 1'b0;
  logic [3:0] drv_v = 4'hC;
  logic [3:0] drv_en = 4'h0;
  // power up with select low, so the first frame has no falling edge
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
  end
  // released lanes: 2 and 3 pulled up, 0 and 1 wander so a stale bit never passes
  always @(posedge core_clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (drv_en[i] && !lane_oe_n[i]) lane_in[i] = 1'bx;
      else if (drv_en[i]) lane_in[i] = drv_v[i];
      else if (!lane_oe_n[i]) lane_in[i] = lane_out[i];
      else lane_in[i] = (i > 1) ? 1'b1 : (flt ^ i[0]);
    end
  end
  // clock parks at the mode's idle level before select falls
  task automatic sel();
    @(posedge core_clk);
    sclk <= mode3;
    drv_en <= 4'hD;
    drv_v <= 4'hC;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic desel();
    @(posedge core_clk);
    sclk <= mode3;
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    drv_en <= 4'hC;
    repeat (8) @(posedge core_clk);
  endtask
  // one byte, msb first; data set at the fall, sampled late in the high phase
  task automatic xfer(input logic [7:0] tx, input int w, input logic rx, output logic [7:0] got);
    logic [7:0] sh;
    sh = tx;
    got = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      @(posedge core_clk);
      sclk <= 1'b0;
      drv_en <= rx ? ((w == 4) ? 4'h0 : 4'hC) : ((w == 1) ? 4'hD : 4'hF);
      drv_v <= (w == 1) ? {3'b110, sh[7]} : (w == 2) ? {2'b11, sh[7:6]} : sh[7:4];
      sh = sh << w;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b1;
      repeat (3) @(posedge core_clk);
      got = (w == 1) ? {got[6:0], lane_in[1]} : (w == 2) ? {got[5:0], lane_in[1:0]} :
        {got[3:0], lane_in};
    end
  endtask
endmodule // snfe_host_model
`default_nettype wire

// ===== test/snfe_front_tb.sv
`default_nettype none
module snfe_front_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // pins and counters
  // ----
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, cs_n, cmd_valid, prog_valid, feat_wr_valid, quad_lane_enable, rd_ready;
  logic [3:0] lane_in, lane_out, lane_oe_n;
  logic [7:0] cmd_code, prog_data, feat_addr, feat_wr_data;
  logic [15:0] cmd_row;
  logic [11:0] cmd_col;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] feat_rd_data = 8'h00;
  logic [7:0] rx [$];
  logic [15:0] n_cmd = 16'h0000, n_prog = 16'h0000, n_feat = 16'h0000, cap_feat;
  logic [11:0] cap_col;
  logic [7:0] cap_prog;
  int bad_count = 0, checks = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  snfe_front u_snfe_front (.core_clk, .arst_n, .sclk, .cs_n, .lane_in, .lane_out, .lane_oe_n,
    .cmd_valid, .cmd_code, .cmd_row, .cmd_col, .prog_valid, .prog_data, .feat_wr_valid,
    .feat_addr, .feat_wr_data, .feat_rd_data, .quad_lane_enable, .rd_valid, .rd_ready, .rd_data);
  snfe_host_model u_host (.core_clk, .sclk, .cs_n, .lane_in, .lane_out, .lane_oe_n);
  // pulses last one cycle, so count and capture them as they pass
  always_ff @(posedge core_clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd <= n_cmd + 16'h0001;
      cap_col <= cmd_col;
    end
    if (prog_valid === 1'b1) begin
      n_prog <= n_prog + 16'h0001;
      cap_prog <= prog_data;
    end
    if (feat_wr_valid === 1'b1) begin
      n_feat <= n_feat + 16'h0001;
      cap_feat <= {feat_addr, feat_wr_data};
    end
  end
  // a hung handshake would otherwise run forever
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic end_of_test();
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // first nx1 bytes single lane, the rest and the reads at width w
  task automatic frame(input logic [7:0] tx [$], input int nx1, input int w, input int nrd);
    logic [7:0] g;
    rx = {};
    u_host.sel();
    foreach (tx[i]) u_host.xfer(tx[i], (i < nx1) ? 1 : w, 1'b0, g);
    repeat (nrd) begin
      u_host.xfer(8'h00, w, 1'b1, g);
      rx.push_back(g);
    end
    u_host.desel();
  endtask
  // two bytes back to back, then the buffer must refuse
  task automatic push2(input logic [15:0] d);
    int n;
    int k;
    n = 0;
    k = 0;
    @(posedge core_clk);
    rd_valid <= 1'b1;
    rd_data <= d[15:8];
    while (k < 2 && n < 50) begin
      @(posedge core_clk);
      n++;
      if (rd_ready === 1'b1) begin
        k++;
        rd_data <= d[7:0];
      end
    end
    rd_valid <= 1'b0;
    @(posedge core_clk);
    chk(16'h0000, 16'(rd_ready));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_power_up();
    frame({8'hFF}, 9, 1, 0);
    chk(16'h0000, n_cmd);
    frame({8'hFF}, 9, 1, 0);
    chk(16'h0001, n_cmd);
    chk(16'h00FF, 16'(cmd_code));
    chk(16'h000F, 16'(lane_oe_n));
  endtask
  task automatic t_feature();
    u_host.mode3 = 1'b1;
    frame({8'h1F, 8'hB0, 8'h01}, 9, 1, 0);
    chk(16'hB001, cap_feat);
    chk(16'h0001, 16'(quad_lane_enable));
    frame({8'h0F, 8'hB0}, 9, 1, 1);
    chk(16'h0001, 16'(rx[0]));
    feat_rd_data <= 8'hA5;
    frame({8'h0F, 8'hC0}, 9, 1, 1);
    chk(16'h00A5, 16'(rx[0]));
    u_host.mode3 = 1'b0;
  endtask
  task automatic t_row();
    logic [7:0] ops [3] = '{8'h13, 8'h10, 8'hD8};
    foreach (ops[i]) begin
      frame({ops[i], 8'h00, 8'hC3, 8'h5A}, 9, 1, 0);
      chk(16'(ops[i]), 16'(cmd_code));
      chk(16'h435A, cmd_row);
    end
  endtask
  // third byte finds the buffer empty and reads as fill
  task automatic t_read();
    logic [7:0] ops [3] = '{8'h03, 8'h3B, 8'h6B};
    foreach (ops[i]) begin
      push2(16'h5AC3);
      frame({ops[i], 8'h08, (i == 2) ? 8'h80 : 8'h7F, 8'h00}, 4, 1 << i, 3);
      chk((i == 2) ? 16'h0000 : 16'h087F, 16'(cap_col));
      chk(16'h5AC3, {rx[0], rx[1]});
      chk(16'h00FF, 16'(rx[2]));
    end
  endtask
  task automatic t_prog();
    frame({8'h32, 8'h00, 8'h10, 8'hA7}, 3, 4, 0);
    chk(16'h00A7, 16'(cap_prog));
    chk(16'h0010, 16'(cap_col));
    frame({8'h02, 8'h00, 8'h11, 8'h3C, 8'h96}, 9, 1, 0);
    chk(16'h0003, n_prog);
    chk(16'h0096, 16'(cap_prog));
  endtask
  // partial data byte, then quad read refused once the enable is cleared
  task automatic t_abort_refuse();
    logic [15:0] c;
    frame({8'h1F, 8'hB0, 8'hF0}, 2, 4, 0);
    chk(16'h0001, n_feat);
    c = n_cmd;
    frame({8'hFF}, 9, 1, 0);
    chk(c + 16'h0001, n_cmd);
    frame({8'h1F, 8'hB0, 8'h00}, 9, 1, 0);
    chk(16'h0000, 16'(quad_lane_enable));
    frame({8'h6B, 8'h00, 8'h00, 8'h00}, 4, 4, 1);
    chk(c + 16'h0001, n_cmd);
    chk(16'h000F, 16'(lane_oe_n));
  endtask
  // pause waits for the clock to be low, then floats the lanes
  task automatic t_pause();
    logic [7:0] g;
    u_host.sel();
    u_host.xfer(8'h0F, 1, 1'b0, g);
    u_host.xfer(8'hB0, 1, 1'b0, g);
    u_host.xfer(8'h00, 1, 1'b1, g);
    u_host.drv_v <= 4'h4;
    repeat (8) @(posedge core_clk);
    chk(16'h000D, 16'(lane_oe_n));
    u_host.sclk <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(16'h000F, 16'(lane_oe_n));
    u_host.desel();
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    t_power_up();
    t_feature();
    t_row();
    t_read();
    t_prog();
    t_abort_refuse();
    t_pause();
    end_of_test();
  end
endmodule // snfe_front_tb
`default_nettype wire
